// file: timer_pkg.sv
// Constants and types for the 8-bit interval / capture / PWM timer
package timer_pkg;
  // Register space addresses
  localparam logic [7:0] CTRL_ADDR  = 8'hF3;
  localparam logic [7:0] REF_ADDR   = 8'hF4;
  localparam logic [7:0] PEND_ADDR  = 8'hF5;
  localparam logic [7:0] COUNT_ADDR = 8'hF6;
  // Control register fields
  localparam int START_BIT  = 0;
  localparam int MC_IE_BIT  = 1;
  localparam int OVF_IE_BIT = 2;
  localparam int CLR_BIT    = 3;
  localparam int MODE_LSB   = 4;
  localparam int CLK_LSB    = 6;
  // Pending register fields
  localparam int PEND_MC_BIT  = 0;
  localparam int PEND_OVF_BIT = 1;
  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] REF_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  // Prescaler divide ratios and tick masks
  localparam int PRESC_W  = 10;
  localparam int DIV_SLOW = 1024;
  localparam int DIV_MID  = 256;
  localparam int DIV_FAST = 64;
  localparam logic [PRESC_W-1:0] MASK_SLOW = PRESC_W'(DIV_SLOW - 1);
  localparam logic [PRESC_W-1:0] MASK_MID  = PRESC_W'(DIV_MID - 1);
  localparam logic [PRESC_W-1:0] MASK_FAST = PRESC_W'(DIV_FAST - 1);
  localparam int PWM_PERIOD = 256;

  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'h0,
    MODE_CAP_RISE = 2'h1,
    MODE_CAP_FALL = 2'h2,
    MODE_PWM      = 2'h3
  } mode_e;

  typedef enum logic [1:0] {
    CLK_DIV_SLOW = 2'h0,
    CLK_DIV_MID  = 2'h1,
    CLK_DIV_FAST = 2'h2,
    CLK_EXT      = 2'h3
  } clk_sel_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// file: timer_a.sv
// 8-bit timer/counter with interval, capture and PWM modes
// What this block does
// R1 - Three modes: interval with toggle, edge capture, PWM; chosen in control register
// R2 - Count clock from system clock divided by 1024, 256 or 64
// R3 - External count pin edges may advance the counter instead
// R4 - 8-bit up-counter, 8-bit equality compare, 8-bit reference register
// R5 - Capture triggers on rising or falling edge, programmable
// R6 - Two interrupts: counter overflow and combined match/capture
// R7 - Software clears pending flags; hardware never clears them on service
// R8 - Interval mode: counter equal to reference gives match and toggles output
// R9 - Interval match raises match interrupt and clears counter, counting continues
// R10 - PWM mode: match does not clear; counter wraps FFH to 00H
// R11 - PWM output low while reference <= counter, high while reference > counter
// R12 - PWM period is 256 count clock periods
// R13 - Control register is 8-bit read/write at address F3H
// R14 - One pin captures input, a separate pin carries PWM/toggle output
// R15 - Shared port pins selectable as timer output, capture and count clock
// R16 - Capture edge loads current counter value into reference register
// R17 - Capture mode: overflow on every wrap, match/capture on every capture
// R18 - Reset clears control to 00H: interval, divide 1024, interrupts off
// R19 - Writing 1 to bit 3 clears counter; writing 1 to bit 0 starts
// R20 - Overflow on wrap from FFH to zero sets pending when enabled
`timescale 1ns/1ps
`default_nettype none
module timer_a #(
  parameter int COUNT_W = 8
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire timer_pkg::reg_req_s reg_req,
  output var  logic [7:0]        reg_rdata,
  input  wire logic              external_count_clock_pin,
  input  wire logic              edge_capture_in_pin,
  input  wire logic              clk_pin_select,
  input  wire logic              cap_pin_select,
  input  wire logic              out_pin_select,
  output var  logic              toggle_pwm_out_pin,
  output logic                   toggle_pwm_oe_n,
  output logic                   wrap_interrupt,
  output logic                   match_capture_interrupt
);
  import timer_pkg::*;

  if (COUNT_W != 8) begin : g_width_check
    $error("timer_a supports only an 8-bit counter");
  end

  logic [7:0]         ctrl_r;
  logic [7:0]         ref_r;
  logic [7:0]         cnt_r;
  logic [PRESC_W-1:0] presc_r;
  logic               pend_mc_r;
  logic               pend_ovf_r;
  logic               ext_s1_r, ext_s2_r, ext_s3_r;
  logic               cap_s1_r, cap_s2_r, cap_s3_r;

  // Register decode
  wire wr_ctrl = reg_req.wr && (reg_req.addr == CTRL_ADDR); // R13
  wire wr_ref  = reg_req.wr && (reg_req.addr == REF_ADDR);
  wire wr_pend = reg_req.wr && (reg_req.addr == PEND_ADDR);
  wire clr_req = wr_ctrl && reg_req.wdata[CLR_BIT]; // R19

  wire       running = ctrl_r[START_BIT];
  wire       mc_ie   = ctrl_r[MC_IE_BIT];
  wire       ovf_ie  = ctrl_r[OVF_IE_BIT];
  mode_e     mode;
  clk_sel_e  clk_sel;
  assign mode    = mode_e'(ctrl_r[MODE_LSB +: 2]); // R1
  assign clk_sel = clk_sel_e'(ctrl_r[CLK_LSB +: 2]);

  // Count clock selection
  wire tick_slow = (presc_r & MASK_SLOW) == MASK_SLOW; // R2
  wire tick_mid  = (presc_r & MASK_MID) == MASK_MID;
  wire tick_fast = (presc_r & MASK_FAST) == MASK_FAST;
  wire tick_ext  = ext_s2_r && !ext_s3_r && clk_pin_select; // R3 R15
  wire tick_sel  = (clk_sel == CLK_DIV_SLOW) ? tick_slow :
                   (clk_sel == CLK_DIV_MID)  ? tick_mid  :
                   (clk_sel == CLK_DIV_FAST) ? tick_fast : tick_ext;
  wire tick      = running && tick_sel && !clr_req;

  // Capture edge detection, third stage keeps the edge off the first flop
  wire cap_rise  = cap_s2_r && !cap_s3_r;
  wire cap_fall  = !cap_s2_r && cap_s3_r;
  wire cap_mode  = (mode == MODE_CAP_RISE) || (mode == MODE_CAP_FALL);
  wire cap_evt   = cap_pin_select && running && // R14 R15
                   (((mode == MODE_CAP_RISE) && cap_rise) || // R5
                    ((mode == MODE_CAP_FALL) && cap_fall));

  wire is_match  = (cnt_r == ref_r); // R4
  wire match_evt = tick && is_match && !cap_mode;
  wire ivl_match = match_evt && (mode == MODE_INTERVAL);
  wire ovf_evt   = tick && (cnt_r == COUNT_MAX) && !ivl_match; // R20
  wire mc_evt    = match_evt || cap_evt; // R6 R17

  logic [7:0] cnt_nxt;
  assign cnt_nxt = clr_req   ? COUNT_RESET : // R19
                   ivl_match ? COUNT_RESET : // R9
                   tick      ? cnt_r + 8'h01 : cnt_r; // R10 R12

  logic [7:0] ref_nxt;
  assign ref_nxt = cap_evt ? cnt_r : // R16
                   wr_ref  ? reg_req.wdata : ref_r;

  // Pending flags: a hardware set beats a same-cycle software clear
  wire pend_mc_nxt  = (mc_evt && mc_ie) || // R7
                      (pend_mc_r && !(wr_pend && !reg_req.wdata[PEND_MC_BIT]));
  wire pend_ovf_nxt = (ovf_evt && ovf_ie) || // R7 R20
                      (pend_ovf_r && !(wr_pend && !reg_req.wdata[PEND_OVF_BIT]));

  logic out_nxt;
  assign out_nxt = (mode == MODE_PWM)  ? (ref_r > cnt_r) : // R11
                   ivl_match           ? !toggle_pwm_out_pin : // R8
                   toggle_pwm_out_pin;

  logic [7:0] rd_mux;
  assign rd_mux = (reg_req.addr == CTRL_ADDR)  ? ctrl_r :
                  (reg_req.addr == REF_ADDR)   ? ref_r  :
                  (reg_req.addr == COUNT_ADDR) ? cnt_r  :
                  (reg_req.addr == PEND_ADDR)  ?
                    {6'h00, pend_ovf_r, pend_mc_r} : 8'h00;

  // Clear bit is a strobe; it never reads back as set
  wire [7:0] ctrl_wval = reg_req.wdata & ~(8'h01 << CLR_BIT);

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_r <= CTRL_RESET; // R18
      ref_r  <= REF_RESET;
      cnt_r  <= COUNT_RESET;
    end else begin
      if (wr_ctrl) ctrl_r <= ctrl_wval;
      ref_r <= ref_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Prescaler free-runs; a clear restarts it so the first interval is exact
  always_ff @(posedge clock) begin
    if (srst || clr_req) presc_r <= '0;
    else                 presc_r <= presc_r + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pend_mc_r          <= 1'b0;
      pend_ovf_r         <= 1'b0;
      toggle_pwm_out_pin <= 1'b0;
      reg_rdata          <= 8'h00;
    end else begin
      pend_mc_r          <= pend_mc_nxt;
      pend_ovf_r         <= pend_ovf_nxt;
      toggle_pwm_out_pin <= out_nxt;
      if (reg_req.rd) reg_rdata <= rd_mux;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      {ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
      {cap_s1_r, cap_s2_r, cap_s3_r} <= 3'h0;
    end else begin
      {ext_s1_r, ext_s2_r, ext_s3_r} <=
        {external_count_clock_pin, ext_s1_r, ext_s2_r};
      {cap_s1_r, cap_s2_r, cap_s3_r} <=
        {edge_capture_in_pin, cap_s1_r, cap_s2_r};
    end
  end

  assign toggle_pwm_oe_n         = !out_pin_select; // R14 R15
  assign wrap_interrupt          = pend_ovf_r; // R6
  assign match_capture_interrupt = pend_mc_r; // R6

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  a_reset_ctrl_zero: assert property ( // R18
    $past(srst) |-> (ctrl_r == 8'h00) && !pend_mc_r && !pend_ovf_r)
    else $error("control not cleared by reset");

  a_clear_counter: assert property ( // R19
    clr_req |=> (cnt_r == 8'h00) && (presc_r == '0))
    else $error("counter not cleared by control write");

  a_interval_match: assert property ( // R8
    ivl_match |=> (cnt_r == 8'h00) &&
                  (toggle_pwm_out_pin != $past(toggle_pwm_out_pin)))
    else $error("interval match did not clear and toggle");

  a_match_pending: assert property ( // R9
    (match_evt && mc_ie) |=> pend_mc_r)
    else $error("match did not set pending");

  a_pwm_wrap: assert property ( // R10
    (tick && (mode == MODE_PWM) && (cnt_r == 8'hFF)) |=>
      (cnt_r == 8'h00) && pend_ovf_r == ($past(pend_ovf_r) || $past(ovf_ie)))
    else $error("pwm counter did not wrap");

  a_pwm_level: assert property ( // R11
    ((mode == MODE_PWM) && !wr_ctrl) |=>
      toggle_pwm_out_pin == ($past(ref_r) > $past(cnt_r)))
    else $error("pwm level wrong");

  a_capture_load: assert property ( // R16
    cap_evt |=> (ref_r == $past(cnt_r)) && (pend_mc_r || !$past(mc_ie)))
    else $error("capture did not load counter");

  a_pend_sticky: assert property ( // R7
    (pend_mc_r && !wr_pend) |=> pend_mc_r [*1] ##0 $stable(pend_mc_r))
    else $error("pending flag cleared without software");

  a_slow_spacing: assert property ( // R2
    (tick_slow && !clr_req) |=> !tick_slow [*8])
    else $error("divide 1024 tick too frequent");

  a_ovf_set: assert property ( // R20
    (ovf_evt && ovf_ie) |=> pend_ovf_r ##1 (pend_ovf_r || $past(wr_pend)))
    else $error("overflow did not set pending");
endmodule // timer_a
`default_nettype wire

// file: ext_pins.sv
// Behavioural model of the timer's external count and capture pins
`timescale 1ns/1ps
`default_nettype none
module ext_pins (
  input  wire logic clock,
  output var  logic count_pin,
  output var  logic cap_pin
);
  initial begin
    count_pin = 1'b0;
    cap_pin   = 1'b0;
  end
  // Pulses outlast the 2-flop sync; the pin stands still between them
  task automatic count_edges(input int n);
    repeat (n) begin
      @(posedge clock) count_pin <= 1'b1;
      repeat (3) @(posedge clock);
      count_pin <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  // Level held long enough for sync plus edge detect
  task automatic set_cap(input logic v);
    @(posedge clock) cap_pin <= v;
    repeat (6) @(posedge clock);
  endtask
endmodule // ext_pins
`default_nettype wire

// file: timer_a_tb.sv
// Self-checking bench for the 8-bit interval / capture / PWM timer
`timescale 1ns/1ps
`default_nettype none
module timer_a_tb;
  import timer_pkg::*;
  logic       clock   = 1'b0;
  logic       srst    = 1'b1;
  reg_req_s   reg_req = '0;
  logic       out_sel = 1'b0;
  logic       clk_sel = 1'b1;
  logic       cap_sel = 1'b1;
  logic [7:0] reg_rdata;
  logic       cnt_pin, cap_pin, out_pin, oe_n, wrap_irq, mc_irq;
  int         error_cnt = 0;
  int         checks    = 0;
  always #25 clock = ~clock;
  ext_pins i_pins (.clock(clock), .count_pin(cnt_pin), .cap_pin(cap_pin));
  timer_a #(.COUNT_W(8)) i_dut (
    .clock(clock), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .external_count_clock_pin(cnt_pin), .edge_capture_in_pin(cap_pin),
    .clk_pin_select(clk_sel), .cap_pin_select(cap_sel),
    .out_pin_select(out_sel),
    .toggle_pwm_out_pin(out_pin), .toggle_pwm_oe_n(oe_n),
    .wrap_interrupt(wrap_irq), .match_capture_interrupt(mc_irq));
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock) reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock) reg_req <= '0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, exp);
    @(posedge clock) reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clock) reg_req <= '0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  // Selects out, wrap or match/capture; a spent bound ends the run
  task automatic wait_sig(input int s, input logic v, input int lim,
                          output int n);
    #1 n = 0;
    while ((s == 0 ? out_pin : s == 1 ? wrap_irq : mc_irq) !== v) begin
      if (n == lim) begin
        error_cnt++;
        complete_run();
      end
      @(posedge clock);
      #1 n++;
    end
  endtask
  task automatic t_reset;
    logic [7:0] a [5] = '{CTRL_ADDR, REF_ADDR, PEND_ADDR, COUNT_ADDR, 8'hF0};
    foreach (a[i]) rc("reset_val", a[i], 8'h00);
    wr(COUNT_ADDR, 8'h55);
    rc("count_ro", COUNT_ADDR, 8'h00);
    @(posedge clock) out_sel <= 1'b1;
    #1 chk("oe_n_on", oe_n, 1'b0);
    @(posedge clock) out_sel <= 1'b0;
    #1 chk("oe_n_off", oe_n, 1'b1);
  endtask
  task automatic t_interval;
    int n;
    wr(REF_ADDR, 8'h02);
    wr(CTRL_ADDR, 8'h8B);
    rc("ctrl_rb", CTRL_ADDR, 8'h83);
    for (int k = 1; k >= 0; k--) begin
      wait_sig(2, 1'b1, 3 * DIV_FAST + 8, n);
      chk("match_late", n > 2 * DIV_FAST, 1'b1);
      @(posedge clock);
      #1 chk("toggle", out_pin, k[0]);
      rc("count_clr", COUNT_ADDR, 8'h00);
      wr(PEND_ADDR, 8'h01);
      rc("pend_kept", PEND_ADDR, 8'h01);
      wr(PEND_ADDR, 8'h00);
      rc("pend_clr", PEND_ADDR, 8'h00);
    end
  endtask
  task automatic t_pwm;
    int n, m;
    wr(REF_ADDR, 8'h50);
    wr(CTRL_ADDR, 8'hBD);
    wait_sig(1, 1'b1, PWM_PERIOD * DIV_FAST + 8, n);
    rc("wrap_cnt", COUNT_ADDR, 8'h00);
    chk("pwm_high", out_pin, 1'b1);
    wait_sig(0, 1'b0, 81 * DIV_FAST, n);
    rc("pwm_fall", COUNT_ADDR, 8'h50);
    // Sync to a rising edge, then time the high and low phases
    wait_sig(0, 1'b1, PWM_PERIOD * DIV_FAST, n);
    wait_sig(0, 1'b0, PWM_PERIOD * DIV_FAST, n);
    wait_sig(0, 1'b1, PWM_PERIOD * DIV_FAST, m);
    chk("pwm_duty", n, 16'h50 * DIV_FAST);
    chk("pwm_period", n + m, PWM_PERIOD * DIV_FAST);
  endtask
  task automatic t_capture;
    wr(PEND_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'hDB);
    i_pins.count_edges(5);
    i_pins.set_cap(1'b1);
    rc("cap_rise", REF_ADDR, 8'h05);
    rc("cap_pend", PEND_ADDR, 8'h01);
    wr(PEND_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'hEB);
    i_pins.count_edges(3);
    i_pins.set_cap(1'b0);
    rc("cap_fall", REF_ADDR, 8'h03);
    wr(PEND_ADDR, 8'h00);
    i_pins.set_cap(1'b1);
    rc("no_rise", PEND_ADDR, 8'h00);
    @(posedge clock) cap_sel <= 1'b0;
    i_pins.set_cap(1'b0);
    rc("cap_unsel", PEND_ADDR, 8'h00);
    @(posedge clock) begin
      cap_sel <= 1'b1;
      clk_sel <= 1'b0;
    end
    i_pins.count_edges(2);
    rc("ext_unsel", COUNT_ADDR, 8'h03);
    @(posedge clock) clk_sel <= 1'b1;
    i_pins.count_edges(1);
    rc("ext_sel", COUNT_ADDR, 8'h04);
  endtask
  // Slower dividers, then a mid-run reset with a pending flag set
  task automatic t_divide;
    int n;
    wr(REF_ADDR, 8'h01);
    wr(PEND_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h4B);
    wait_sig(2, 1'b1, 2 * DIV_MID + 8, n);
    chk("div_mid", n, 2 * DIV_MID);
    wr(PEND_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h0B);
    wait_sig(2, 1'b1, 2 * DIV_SLOW + 8, n);
    chk("div_slow", n, 2 * DIV_SLOW);
    @(posedge clock) srst <= 1'b1;
    @(posedge clock) srst <= 1'b0;
    #1 chk("rst_irq", mc_irq, 1'b0);
    rc("rst_ctrl", CTRL_ADDR, 8'h00);
    rc("rst_pend", PEND_ADDR, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_interval();
    t_pwm();
    t_capture();
    t_divide();
    complete_run();
  end
endmodule // timer_a_tb
`default_nettype wire
